// [hdl/line_select_driver.sv]
// line select driver top: serial register, pin synchronisers and section outputs
`timescale 1ns/1ps
`include "line_select_map.svh"
module line_select_driver
   import line_select_pkg::*;
#(
   parameter int STAGES = `LS_STAGES,
   parameter int SECTIONS = `LS_SECTIONS
)
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_serial_data,
   input wire logic i_shift_clk,
   input wire logic i_section_select_low,
   input wire logic i_section_select_high,
   input wire logic i_output_gate_n,
   output logic [SECTIONS*STAGES-1:0] o_section_output
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic data_meta_r;
   logic data_sync_r;
   logic shift_clk_meta_r;
   logic shift_clk_sync_r;
   logic shift_clk_d_r;
   sel_code_t sel_meta_r;
   sel_code_t sel_sync_r;
   logic gate_n_meta_r;
   logic gate_n_sync_r;
   logic shift_edge;
   logic [STAGES-1:0] stage_r;

   // serial data pin, two flops
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         data_meta_r <= `LS_DATA_RST;
         data_sync_r <= `LS_DATA_RST;
      end
      else if (i_ce)
      begin
         data_meta_r <= i_serial_data;
         data_sync_r <= data_meta_r;
      end
   end

   // shift clock pin, two flops
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         shift_clk_meta_r <= `LS_SHIFT_CLK_RST;
         shift_clk_sync_r <= `LS_SHIFT_CLK_RST;
      end
      else if (i_ce)
      begin
         shift_clk_meta_r <= i_shift_clk;
         shift_clk_sync_r <= shift_clk_meta_r;
      end
   end

   // select pins, two flops
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         sel_meta_r <= `LS_SEL_RST;
         sel_sync_r <= `LS_SEL_RST;
      end
      else if (i_ce)
      begin
         sel_meta_r <= {i_section_select_high, i_section_select_low};
         sel_sync_r <= sel_meta_r;
      end
   end

   // strobe pin, two flops, rests high
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         gate_n_meta_r <= `LS_GATE_N_RST;
         gate_n_sync_r <= `LS_GATE_N_RST;
      end
      else if (i_ce)
      begin
         gate_n_meta_r <= i_output_gate_n;
         gate_n_sync_r <= gate_n_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // shift clock edge detect
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         shift_clk_d_r <= `LS_SHIFT_CLK_RST;
      end
      else if (i_ce)
      begin
         shift_clk_d_r <= shift_clk_sync_r;
      end
   end

   assign shift_edge = shift_clk_sync_r && !shift_clk_d_r;

   // ----------------------------------------------------------------
   // serial register
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         stage_r <= `LS_STAGE_RST;
      end
      else if (i_ce && shift_edge)
      begin
         stage_r <= {stage_r[STAGES-2:0], ~data_sync_r};
      end
   end

   // ----------------------------------------------------------------
   // section decode
   // ----------------------------------------------------------------
   section_bus_if #(.STAGES(STAGES), .SECTIONS(SECTIONS)) bus ();

   assign bus.pattern = stage_r;
   assign bus.sel = sel_sync_r;
   assign bus.gate_n = gate_n_sync_r;

   section_decoder #(.STAGES(STAGES), .SECTIONS(SECTIONS)) u_dec (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .bus(bus.decoder)
   );

   assign o_section_output = bus.outputs;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   load_invert_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && shift_edge |=> stage_r[0] == !$past(data_sync_r))
      else $error("stage one not inverted data");

   shift_move_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && shift_edge |=> stage_r[STAGES-1:1] == $past(stage_r[STAGES-2:0]))
      else $error("register did not shift");

   shift_once_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && shift_edge |=> !shift_edge)
      else $error("one clock edge shifted twice");

   hold_stage_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !(i_ce && shift_edge) |=> $stable(stage_r))
      else $error("register changed without edge");

   strobe_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !gate_n_sync_r && !(i_ce && shift_edge) |=> $stable(stage_r))
      else $error("register changed during strobe");

   ce_freeze_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !i_ce |=> $stable(stage_r) && $stable(o_section_output) && $stable(shift_clk_d_r))
      else $error("state moved while clock enable low");

   pin_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && gate_n_sync_r |=> o_section_output == '0)
      else $error("outputs high while strobe high");

   route_one_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !gate_n_sync_r && sel_sync_r == `LS_CODE_ONE
      |=> o_section_output[`LS_SEC_ONE*STAGES +: STAGES] == $past(stage_r))
      else $error("section one does not follow register");

   route_two_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !gate_n_sync_r && sel_sync_r == `LS_CODE_TWO
      |=> o_section_output[`LS_SEC_TWO*STAGES +: STAGES] == $past(stage_r))
      else $error("section two does not follow register");

   route_three_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !gate_n_sync_r && sel_sync_r == `LS_CODE_THREE
      |=> o_section_output[`LS_SEC_THREE*STAGES +: STAGES] == $past(stage_r))
      else $error("section three does not follow register");

   route_four_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !gate_n_sync_r && sel_sync_r == `LS_CODE_FOUR
      |=> o_section_output[`LS_SEC_FOUR*STAGES +: STAGES] == $past(stage_r))
      else $error("section four does not follow register");

   blank_two_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !gate_n_sync_r && sel_sync_r == `LS_CODE_TWO
      |=> o_section_output[`LS_SEC_ONE*STAGES +: STAGES] == '0
      && o_section_output[`LS_SEC_THREE*STAGES +: STAGES] == '0
      && o_section_output[`LS_SEC_FOUR*STAGES +: STAGES] == '0)
      else $error("unselected section driven");

   blank_three_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !gate_n_sync_r && sel_sync_r == `LS_CODE_THREE
      |=> o_section_output[`LS_SEC_ONE*STAGES +: STAGES] == '0
      && o_section_output[`LS_SEC_TWO*STAGES +: STAGES] == '0
      && o_section_output[`LS_SEC_FOUR*STAGES +: STAGES] == '0)
      else $error("unselected section driven");

   blank_four_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !gate_n_sync_r && sel_sync_r == `LS_CODE_FOUR
      |=> o_section_output[`LS_SEC_ONE*STAGES +: STAGES] == '0
      && o_section_output[`LS_SEC_TWO*STAGES +: STAGES] == '0
      && o_section_output[`LS_SEC_THREE*STAGES +: STAGES] == '0)
      else $error("unselected section driven");
endmodule : line_select_driver

// [hdl/line_select_map.svh]
// constant map for the line select driver
`ifndef LINE_SELECT_MAP_SVH
`define LINE_SELECT_MAP_SVH
`define LS_STAGES 8
`define LS_SECTIONS 4
`define LS_SEL_W 2
`define LS_STAGE_RST 8'h00
`define LS_OUT_IDLE 32'h0000_0000
`define LS_DATA_RST 1'h0
`define LS_SHIFT_CLK_RST 1'h0
`define LS_SEL_RST 2'h3
`define LS_GATE_N_RST 1'h1
`define LS_CODE_ONE 2'h0
`define LS_CODE_TWO 2'h1
`define LS_CODE_THREE 2'h2
`define LS_CODE_FOUR 2'h3
`define LS_SEC_ONE 32'h0
`define LS_SEC_TWO 32'h1
`define LS_SEC_THREE 32'h2
`define LS_SEC_FOUR 32'h3
`endif

// [hdl/line_select_pkg.sv]
// types for the line select driver
package line_select_pkg;
   typedef logic [1:0] sel_code_t;
endpackage : line_select_pkg

// [hdl/section_bus_if.sv]
// interface between the shift register core and the section decoder
`timescale 1ns/1ps
interface section_bus_if #(parameter int STAGES = 8, parameter int SECTIONS = 4);
   logic [STAGES-1:0] pattern;
   logic [1:0] sel;
   logic gate_n;
   logic [SECTIONS*STAGES-1:0] outputs;
   modport core (output pattern, output sel, output gate_n, input outputs);
   modport decoder (input pattern, input sel, input gate_n, output outputs);
endinterface : section_bus_if

// [hdl/section_decoder.sv]
// two-to-four section decoder gated by the output strobe
`timescale 1ns/1ps
`include "line_select_map.svh"
module section_decoder
   import line_select_pkg::*;
#(
   parameter int STAGES = `LS_STAGES,
   parameter int SECTIONS = `LS_SECTIONS
)
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   section_bus_if.decoder bus
);
   logic [SECTIONS*STAGES-1:0] out_r;
   logic [SECTIONS*STAGES-1:0] out_nxt;

   always_comb
   begin
      out_nxt = '0;
      if (!bus.gate_n)
      begin
         for (int s = 0; s < SECTIONS; s++)
         begin
            if (bus.sel == s[1:0])
            begin
               out_nxt[s*STAGES +: STAGES] = bus.pattern;
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         out_r <= `LS_OUT_IDLE;
      end
      else if (i_ce)
      begin
         out_r <= out_nxt;
      end
   end

   assign bus.outputs = out_r;

   gate_rest_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && bus.gate_n |=> out_r == '0)
      else $error("outputs high while strobe high");
   unsel_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !bus.gate_n && bus.sel == 2'h0 |=> out_r[SECTIONS*STAGES-1:STAGES] == '0)
      else $error("unselected section driven");
   sel_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_ce && !bus.gate_n && bus.sel == 2'h3
      |=> out_r[3*STAGES +: STAGES] == $past(bus.pattern))
      else $error("selected section does not follow register");
endmodule : section_decoder

// [sim/display_ctrl_model.sv]
// display controller model driving the serial and strobe pins
`timescale 1ns/1ps
module display_ctrl_model
(
   input wire logic i_ref_clk,
   output logic o_data,
   output logic o_shift_clk,
   output logic [1:0] o_sel,
   output logic o_gate_n
);
   initial
   begin
      o_data = 1'b0;
      o_shift_clk = 1'b0;
      o_sel = 2'h0;
      o_gate_n = 1'b1;
   end
   // data set up before the rising shift edge, clock high and low 3 cycles each
   task automatic put_bit(input logic b);
   begin
      o_data <= b;
      repeat (3) @(posedge i_ref_clk);
      o_shift_clk <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      o_shift_clk <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
   end
   endtask : put_bit
   // data pin moves with no shift clock edge
   task automatic set_data(input logic b);
   begin
      o_data <= b;
      repeat (3) @(posedge i_ref_clk);
   end
   endtask : set_data
   // select settles before the strobe moves and is held after it
   task automatic set_gate(input logic [1:0] s, input logic g);
   begin
      o_sel <= s;
      repeat (3) @(posedge i_ref_clk);
      o_gate_n <= g;
      repeat (6) @(posedge i_ref_clk);
   end
   endtask : set_gate
endmodule : display_ctrl_model

// [sim/plasma_line_select_driver_bench.sv]
// self-checking bench for the line select driver
`timescale 1ns/1ps
module plasma_line_select_driver_bench;
   import line_select_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic data;
   logic sclk;
   logic gate_n;
   sel_code_t sel;
   logic [31:0] outs;
   logic [7:0] exp_r = 8'h00;
   logic ce = 1'b1;
   int err_count = 0;
   int comparisons = 0;
   always #10 ref_clk = ~ref_clk;
   display_ctrl_model ctrl (.i_ref_clk(ref_clk), .o_data(data), .o_shift_clk(sclk),
      .o_sel(sel), .o_gate_n(gate_n));
   line_select_driver uut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_ce(ce),
      .i_serial_data(data), .i_shift_clk(sclk), .i_section_select_low(sel[0]),
      .i_section_select_high(sel[1]), .i_output_gate_n(gate_n), .o_section_output(outs));
   // outputs are read at the falling edge, where they have settled
   task automatic check_outs(input logic [31:0] exp);
   begin
      @(negedge ref_clk);
      comparisons++;
      if (outs !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, outs, exp);
      end
      @(posedge ref_clk);
   end
   endtask : check_outs
   task automatic load(input logic [7:0] pat);
   begin
      for (int i = 7; i >= 0; i--)
      begin
         ctrl.put_bit(pat[i]);
         exp_r = {exp_r[6:0], ~pat[i]};
      end
   end
   endtask : load
   task automatic test_sections;
   begin
      for (int s = 0; s < 4; s++)
      begin
         load(8'h4B + 8'(s));
         check_outs(32'h0000_0000);
         ctrl.set_gate(2'(s), 1'b0);
         check_outs(32'(exp_r) << (8 * s));
         ctrl.set_gate(2'(s), 1'b1);
         check_outs(32'h0000_0000);
      end
      $display("test_sections done");
   end
   endtask : test_sections
   task automatic test_shift_hold;
   begin
      ctrl.put_bit(1'b1);
      exp_r = {exp_r[6:0], 1'b0};
      ctrl.set_gate(2'h2, 1'b0);
      check_outs(32'(exp_r) << 16);
      ctrl.set_data(1'b0);
      ctrl.set_data(1'b1);
      repeat (20) @(posedge ref_clk);
      check_outs(32'(exp_r) << 16);
      ctrl.set_gate(2'h2, 1'b1);
      $display("test_shift_hold done");
   end
   endtask : test_shift_hold
   task automatic test_ce_freeze;
   begin
      ctrl.set_gate(2'h1, 1'b0);
      check_outs(32'(exp_r) << 8);
      ce <= 1'b0;
      ctrl.put_bit(1'b0);
      check_outs(32'(exp_r) << 8);
      ce <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check_outs(32'(exp_r) << 8);
      ctrl.set_gate(2'h1, 1'b1);
      check_outs(32'h0000_0000);
      $display("test_ce_freeze done");
   end
   endtask : test_ce_freeze
   task automatic print_verdict;
   begin
      $display("checks=%0d errors=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask : print_verdict
   initial
   begin
      #200000;
      err_count++;
      print_verdict();
   end
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      test_sections();
      test_shift_hold();
      test_ce_freeze();
      print_verdict();
   end
endmodule : plasma_line_select_driver_bench
